// [remote_serial_end.sv]
// remote serial end sharing the transmit pin
module remote_serial_end (
  input wire logic oe_n_i,
  input wire logic dev_o_i,
  input wire logic far_level_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // device drives while enable low, far end drives otherwise
  assign line_o = oe_n_i ? far_level_i : dev_o_i;
endmodule : remote_serial_end

// [uart_ctrl_pkg.sv]
// constants and types for the transmit pin and error interrupt control block
package uart_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // control three sits at index 6, one 32-bit word per index
  localparam logic [ADDR_W-1:0] CTRL3_INDEX = 8'h06;
  localparam logic [ADDR_W-1:0] CTRL3_ADDR = {CTRL3_INDEX[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] MODE_ADDR = 8'h40;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 8'h44;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h48;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h4C;
  // field positions in control three
  localparam int SOW_POS = 5;
  localparam int INV_POS = 4;
  localparam int ENABLE_POS = 0;
  localparam logic [7:0] CTRL3_WRITE_MASK = 8'h3F;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  typedef struct packed {
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } err_flags_t;

  typedef struct packed {
    logic [1:0] ninth_bits;
    logic single_wire_output_select;
    logic transmit_polarity_invert;
    err_flags_t irq_enable;
  } ctrl3_t;

  typedef struct packed {
    logic receiver_source_select;
    logic loop_mode_select;
  } mode_t;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage : uart_ctrl_pkg

// [uart_txpin_and_error_irq_control.sv]
// transmit pin direction, polarity and error interrupt control with avalon slave
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
module uart_txpin_and_error_irq_control (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [uart_ctrl_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [uart_ctrl_pkg::DATA_W-1:0] writedata_i,
  output logic [uart_ctrl_pkg::DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  input wire uart_ctrl_pkg::err_flags_t err_flags_i,
  input wire logic tx_level_i,
  input wire logic tx_line_i,
  output logic tx_line_o,
  output logic tx_line_oe_n_o,
  output logic single_wire_rx_o,
  output logic error_irq_o,
  output logic irq_o
);
  import uart_ctrl_pkg::*;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  ctrl3_t ctrl3;
  ctrl3_t next_ctrl3;
  mode_t mode;
  mode_t next_mode;
  logic [3:0] mask;
  logic [3:0] next_mask;
  logic [3:0] status;
  logic [3:0] next_status;
  err_flags_t flags_prev;
  bus_state_t bus_state;
  bus_state_t next_bus_state;

  // bus decode
  wire logic request = read_i | write_i;
  wire logic answer = (bus_state == BUS_IDLE) && request;
  // writes land at the edge where the master sees waitrequest low
  wire logic complete = (bus_state == BUS_ANSWER) && request;
  wire logic take_write = complete && write_i;
  wire logic take_read = answer && read_i;
  wire logic hit_ctrl3 = address_i == CTRL3_ADDR;
  wire logic hit_mode = address_i == MODE_ADDR;
  wire logic hit_flags = address_i == FLAGS_ADDR;
  wire logic hit_status = address_i == STATUS_ADDR;
  wire logic hit_mask = address_i == MASK_ADDR;

  wire logic [7:0] ctrl3_bits = ctrl3 & CTRL3_WRITE_MASK;
  wire logic [DATA_W-1:0] read_value =
    hit_ctrl3 ? {24'h000000, ctrl3_bits} :
    hit_mode ? {30'h00000000, mode} :
    hit_flags ? {28'h0000000, err_flags_i} :
    hit_status ? {28'h0000000, status} :
    hit_mask ? {28'h0000000, mask} : 32'h00000000;

  // register writes, ninth data bits are not held here
  assign next_ctrl3 = (take_write && hit_ctrl3) ?
    ctrl3_t'(writedata_i[7:0] & CTRL3_WRITE_MASK) : ctrl3;
  assign next_mode = (take_write && hit_mode) ? mode_t'(writedata_i[1:0]) : mode;
  assign next_mask = (take_write && hit_mask) ? writedata_i[3:0] : mask;

  // sticky events on each rising error flag, read clears, a new event wins
  wire logic [3:0] flag_rise = err_flags_i & ~flags_prev;
  wire logic [3:0] status_kept = (take_read && hit_status) ? STATUS_RESET : status;
  assign next_status = status_kept | flag_rise;

  // pin control
  wire logic single_wire = mode.loop_mode_select & mode.receiver_source_select;
  wire logic sow = ctrl3.single_wire_output_select;
  wire logic inv = ctrl3.transmit_polarity_invert;
  wire logic next_oe_n = single_wire & ~sow;
  wire logic next_tx_line = tx_level_i ^ inv;

  // error request from enabled flags
  wire logic [3:0] enabled_flags = err_flags_i & ctrl3.irq_enable;
  wire logic next_error_irq = |enabled_flags;
  wire logic next_irq = |(next_status & mask);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ctrl3 <= ctrl3_t'(CTRL3_RESET);
    end
    else
    begin
      ctrl3 <= next_ctrl3;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mode <= mode_t'(MODE_RESET);
    end
    else
    begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mask <= MASK_RESET;
    end
    else
    begin
      mask <= next_mask;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      flags_prev <= err_flags_t'(STATUS_RESET);
    end
    else
    begin
      flags_prev <= err_flags_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      bus_state <= BUS_IDLE;
    end
    else
    begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      readdata_o <= 32'h00000000;
      waitrequest_o <= 1'b1;
    end
    else
    begin
      waitrequest_o <= ~answer;
      if (take_read)
      begin
        readdata_o <= read_value;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_line_o <= 1'b1;
    end
    else
    begin
      tx_line_o <= next_tx_line;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_line_oe_n_o <= 1'b0;
    end
    else
    begin
      tx_line_oe_n_o <= next_oe_n;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      single_wire_rx_o <= 1'b1;
    end
    else
    begin
      single_wire_rx_o <= tx_line_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      error_irq_o <= 1'b0;
    end
    else
    begin
      error_irq_o <= next_error_irq;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= next_irq;
    end
  end

  // bus handshake, one wait cycle then the answer cycle
  always_comb
  begin
    case (bus_state)
      BUS_IDLE: next_bus_state = request ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: next_bus_state = BUS_IDLE;
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  pin_input_a: assert property (
    (single_wire && !sow) |=> tx_line_oe_n_o)
    else $error("pin not released in single-wire input mode");

  pin_output_a: assert property (
    (!single_wire || sow) |=> !tx_line_oe_n_o)
    else $error("pin not driven when output is selected");

  tx_invert_a: assert property (
    inv |=> tx_line_o == !$past(tx_level_i))
    else $error("transmit line not inverted");

  tx_plain_a: assert property (
    (!inv && $stable(tx_level_i)) |=> tx_line_o == $past(tx_level_i))
    else $error("transmit line altered while not inverted");

  reset_invert_a: assert property (
    $past(rst_i) |-> !inv && tx_line_o)
    else $error("invert bit or idle level wrong after reset");

  overrun_irq_a: assert property (
    (err_flags_i.overrun && ctrl3.irq_enable.overrun) |=> error_irq_o)
    else $error("overrun request missing");

  noise_irq_a: assert property (
    (err_flags_i.noise && ctrl3.irq_enable.noise) |=> error_irq_o)
    else $error("noise request missing");

  framing_irq_a: assert property (
    (err_flags_i.framing && ctrl3.irq_enable.framing) |=> error_irq_o)
    else $error("framing request missing");

  parity_irq_a: assert property (
    (err_flags_i.parity && ctrl3.irq_enable.parity) |=> error_irq_o)
    else $error("parity request missing");

  irq_drop_a: assert property (
    !(|(err_flags_i & ctrl3.irq_enable)) |=> !error_irq_o)
    else $error("error request stays without enabled flag");

  sticky_set_a: assert property (
    $rose(err_flags_i.overrun) |=> status[3] ##1 (status[3] || $past(take_read && hit_status)))
    else $error("overrun event not held");

  bus_answer_a: assert property (
    (request && waitrequest_o) |-> ##[0:1] !waitrequest_o)
    else $error("bus request not answered");

  write_commit_a: assert property (
    (complete && write_i && hit_mask) |=> mask == $past(writedata_i[3:0]))
    else $error("mask write not taken at the answer edge");

  ctrl3_commit_a: assert property (
    (complete && write_i && hit_ctrl3) |=>
      ctrl3 == ctrl3_t'($past(writedata_i[7:0]) & CTRL3_WRITE_MASK))
    else $error("control three write not taken");

  wait_one_a: assert property (
    !waitrequest_o |=> waitrequest_o)
    else $error("waitrequest held low too long");

  read_data_a: assert property (
    (take_read && hit_status) |=> readdata_o == {28'h0000000, $past(status)})
    else $error("status read value wrong");

  read_clear_a: assert property (
    (take_read && hit_status && !(|flag_rise)) |=> status == STATUS_RESET)
    else $error("status not cleared by read");

  irq_level_a: assert property (
    (|(status & mask) && !(take_read && hit_status)) |=> irq_o)
    else $error("interrupt missing with unmasked status");
endmodule : uart_txpin_and_error_irq_control

// [uart_txpin_and_error_irq_control_tb.sv]
// testbench for transmit pin and error interrupt control
module uart_txpin_and_error_irq_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_ctrl_pkg::*;
  logic clock = 0, rst = 1, rd = 0, wr = 0, lvl = 1, far = 1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, v;
  logic wait_o, line, tx_o, oe_n, swrx, eirq, irq;
  err_flags_t flags = 4'h0;
  int mismatches = 0, compares = 0, cyc = 0;
  uart_txpin_and_error_irq_control uart_txpin_and_error_irq_control_i (
    .clock_i(clock), .rst_i(rst), .address_i(addr), .read_i(rd), .write_i(wr),
    .writedata_i(wd), .readdata_o(rdata), .waitrequest_o(wait_o), .err_flags_i(flags),
    .tx_level_i(lvl), .tx_line_i(line), .tx_line_o(tx_o), .tx_line_oe_n_o(oe_n),
    .single_wire_rx_o(swrx), .error_irq_o(eirq), .irq_o(irq));
  remote_serial_end remote_serial_end_i (
    .oe_n_i(oe_n), .dev_o_i(tx_o), .far_level_i(far), .line_o(line));
  initial forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  task conclude();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clock);
    while (wait_o !== 1'b0) @(posedge clock);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask : bus
  task reset_state();
    bus(0, CTRL3_ADDR, 32'h0);
    chk("ctrl3", 32'h0, v);
    chk("tx_idle", 32'h1, {31'h0, tx_o});
    bus(0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, v);
  endtask : reset_state
  task inversion();
    bus(1, CTRL3_ADDR, 32'h10);
    for (int i = 0; i < 2; i++)
    begin
      lvl <= i[0];
      tick(3);
      chk("tx_inv", {31'h0, !i[0]}, {31'h0, tx_o});
    end
    bus(1, CTRL3_ADDR, 32'h0);
    lvl <= 1'b0;
    tick(3);
    chk("tx_plain", 32'h0, {31'h0, tx_o});
  endtask : inversion
  task single_wire();
    bus(1, MODE_ADDR, 32'h3);
    bus(0, MODE_ADDR, 32'h0);
    chk("mode", 32'h3, v);
    tick(2);
    chk("oe_in", 32'h1, {31'h0, oe_n});
    far <= 1'b0;
    tick(3);
    chk("sw_rx", 32'h0, {31'h0, swrx});
    bus(1, CTRL3_ADDR, 32'h20);
    tick(2);
    chk("oe_out", 32'h0, {31'h0, oe_n});
    bus(1, MODE_ADDR, 32'h0);
  endtask : single_wire
  task enables();
    for (int i = 0; i < 4; i++)
    begin
      flags <= 4'h1 << i;
      bus(1, CTRL3_ADDR, 32'h1 << i);
      tick(2);
      chk("irq_on", 32'h1, {31'h0, eirq});
      bus(1, CTRL3_ADDR, 32'hF ^ (32'h1 << i));
      tick(2);
      chk("irq_off", 32'h0, {31'h0, eirq});
    end
    flags <= 4'h0;
  endtask : enables
  task sticky();
    bus(0, STATUS_ADDR, 32'h0);
    chk("status_prior", 32'hF, v);
    bus(1, MASK_ADDR, 32'h8);
    tick(2);
    chk("irq_idle", 32'h0, {31'h0, irq});
    flags <= 4'h8;
    tick(3);
    chk("irq", 32'h1, {31'h0, irq});
    chk("eirq_masked", 32'h0, {31'h0, eirq});
    bus(0, FLAGS_ADDR, 32'h0);
    chk("flags", 32'h8, v);
    flags <= 4'h0;
    bus(0, STATUS_ADDR, 32'h0);
    chk("status", 32'h8, v);
    tick(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : sticky
  initial
  begin
    tick(8);
    rst <= 1'b0;
    tick(1);
    reset_state();
    inversion();
    single_wire();
    enables();
    sticky();
    conclude();
  end
endmodule : uart_txpin_and_error_irq_control_tb
